/* hdl/watchdog_timer.sv */
// Function
// - Count advances only on low-power oscillator edges while enabled.
// - Awake timeout resets the device unless software services the count in time.
// - Configured postscaler selects timeout period as two to its power ticks.
// - Counting continues in Sleep or Idle; timeout there wakes the device.
// - Enabled by configuration bit or software enable bit, either suffices.
// - Awake timeout: device reset, register reset, timeout flag set, no interrupt (here irq_o still rises when the timeout event is unmasked).
// - Sleep or Idle timeout: no reset, interrupt raised, timeout plus mode flag set.
// - Timeout, Sleep, Idle flags live in the reset-cause register.
// - Clear, set, invert aliases affect only bits written one; reads undefined.
// - Software enable one starts; zero stops only a software-started watchdog.
// - Writing one to clear bit restarts the count; bit reads zero.
// - Five-bit read-only field mirrors the configured postscaler value.
// - Timeout flag stays set until software clears it.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module watchdog_timer
    import watchdog_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Configuration and power mode
    input wire logic cfg_enable_i,
    input wire logic [4:0] cfg_postscale_i,
    input wire logic sleep_i,
    input wire logic idle_i,
    // Oscillator pin
    input wire logic low_power_osc_clock_i,
    // Device effects
    output logic device_reset_o,
    output logic nmi_o,
    output logic wake_o,
    output logic irq_o
);
    import watchdog_timer_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] apply_write(input logic [31:0] old_val, input logic [31:0] wval,
                                                input write_kind_t kind);
        logic [31:0] res;
        res = old_val;
        unique case (kind)
            WR_PLAIN: res = wval;
            WR_CLEAR: res = old_val & ~wval;
            WR_SET: res = old_val | wval;
            WR_INVERT: res = old_val ^ wval;
        endcase
        return res;
    endfunction

    function automatic logic [CNT_W-1:0] terminal_count(input logic [4:0] ps);
        logic [CNT_W-1:0] one;
        one = {{(CNT_W-1){1'b0}}, 1'b1};
        return (one << ps) - one;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic sw_on_reg;
    logic sw_on_next;
    logic [2:0] cause_reg;
    logic [2:0] cause_next;
    logic [EVT_W-1:0] status_reg;
    logic [EVT_W-1:0] status_next;
    logic [EVT_W-1:0] mask_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic osc_meta_reg;
    logic osc_sync_reg;
    logic osc_prev_reg;
    logic [31:0] rdata_reg;
    logic reset_pulse_reg;
    logic nmi_pulse_reg;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire hit_ctrl = addr_i == WDOG_CTRL_ADDR;
    wire hit_ctrl_clr = addr_i == WDOG_CTRL_CLR_ADDR;
    wire hit_ctrl_set = addr_i == WDOG_CTRL_SET_ADDR;
    wire hit_ctrl_inv = addr_i == WDOG_CTRL_INV_ADDR;
    wire hit_status = addr_i == EVT_STATUS_ADDR;
    wire hit_mask = addr_i == EVT_MASK_ADDR;
    wire hit_cause = addr_i == CAUSE_ADDR;
    wire hit_cause_clr = addr_i == CAUSE_CLR_ADDR;
    wire hit_cause_set = addr_i == CAUSE_SET_ADDR;
    wire hit_cause_inv = addr_i == CAUSE_INV_ADDR;

    wire ctrl_wr = wr_i & (hit_ctrl | hit_ctrl_clr | hit_ctrl_set | hit_ctrl_inv);
    wire cause_wr = wr_i & (hit_cause | hit_cause_clr | hit_cause_set | hit_cause_inv);

    write_kind_t ctrl_kind;
    write_kind_t cause_kind;
    assign ctrl_kind = hit_ctrl_clr ? WR_CLEAR : hit_ctrl_set ? WR_SET : hit_ctrl_inv ? WR_INVERT : WR_PLAIN;
    assign cause_kind = hit_cause_clr ? WR_CLEAR : hit_cause_set ? WR_SET : hit_cause_inv ? WR_INVERT : WR_PLAIN;

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    // The clear bit always holds zero, so applying a write to zero tells whether a one lands there.
    wire [31:0] ctrl_old = {16'h0, sw_on_reg, 15'h0};
    wire [31:0] ctrl_wval = apply_write(ctrl_old, wdata_i, ctrl_kind);
    wire service = ctrl_wr & ctrl_wval[CTRL_CLR_BIT];

    wire enabled = cfg_enable_i | sw_on_reg;
    wire in_low_power = sleep_i | idle_i;

    // ----------------------------------------
    // Oscillator tick and counter
    // ----------------------------------------
    wire osc_tick = osc_sync_reg & ~osc_prev_reg;
    wire [CNT_W-1:0] term = terminal_count(cfg_postscale_i);
    wire timeout = enabled & osc_tick & ~service & (cnt_reg == term);
    wire timeout_awake = timeout & ~in_low_power;
    wire timeout_asleep = timeout & in_low_power;

    always_comb
    begin
        cnt_next = cnt_reg;
        if (!enabled || service || timeout)
        begin
            cnt_next = '0;
        end
        else if (osc_tick)
        begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    // Awake timeout also returns the software enable to its reset value; the event mask and status registers do not reset.
    always_comb
    begin
        sw_on_next = sw_on_reg;
        if (ctrl_wr)
        begin
            sw_on_next = ctrl_wval[CTRL_ON_BIT];
        end
        if (timeout_awake)
        begin
            sw_on_next = CTRL_ON_RST;
        end
    end

    // ----------------------------------------
    // Reset-cause flags
    // ----------------------------------------
    // Hardware sets win over a software clear landing in the same cycle.
    wire [31:0] cause_old = {27'h0, cause_reg[2], cause_reg[1], cause_reg[0], 2'h0};
    wire [31:0] cause_wval = apply_write(cause_old, wdata_i, cause_kind);

    always_comb
    begin
        cause_next = cause_reg;
        if (cause_wr)
        begin
            cause_next = {cause_wval[CAUSE_TIMEOUT_BIT], cause_wval[CAUSE_SLEEP_BIT], cause_wval[CAUSE_IDLE_BIT]};
        end
        if (timeout)
        begin
            cause_next[2] = 1'b1;
        end
        if (timeout_asleep && sleep_i)
        begin
            cause_next[1] = 1'b1;
        end
        if (timeout_asleep && !sleep_i)
        begin
            cause_next[0] = 1'b1;
        end
    end

    // ----------------------------------------
    // Event status and interrupt
    // ----------------------------------------
    wire status_rd = rd_i & hit_status;
    wire [EVT_W-1:0] events = {service, timeout};

    always_comb
    begin
        status_next = status_rd ? EVT_RST : status_reg;
        status_next = status_next | events;
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        if (hit_ctrl)
        begin
            rd_mux[CTRL_ON_BIT] = enabled;
            rd_mux[CTRL_PS_LSB +: CTRL_PS_W] = cfg_postscale_i;
        end
        else if (hit_cause)
        begin
            rd_mux[CAUSE_TIMEOUT_BIT] = cause_reg[2];
            rd_mux[CAUSE_SLEEP_BIT] = cause_reg[1];
            rd_mux[CAUSE_IDLE_BIT] = cause_reg[0];
        end
        else if (hit_status)
        begin
            rd_mux[EVT_W-1:0] = status_reg;
        end
        else if (hit_mask)
        begin
            rd_mux[EVT_W-1:0] = mask_reg;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end
        else
        begin
            osc_meta_reg <= low_power_osc_clock_i;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_reg <= '0;
            sw_on_reg <= CTRL_ON_RST;
            cause_reg <= CAUSE_RST;
            status_reg <= EVT_RST;
        end
        else
        begin
            cnt_reg <= cnt_next;
            sw_on_reg <= sw_on_next;
            cause_reg <= cause_next;
            status_reg <= status_next;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mask_reg <= EVT_RST;
        end
        else if (wr_i && hit_mask)
        begin
            mask_reg <= wdata_i[EVT_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_reg <= 32'h0;
            reset_pulse_reg <= 1'b0;
            nmi_pulse_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rd_i ? rd_mux : 32'h0;
            reset_pulse_reg <= timeout_awake;
            nmi_pulse_reg <= timeout_asleep;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata_o = rdata_reg;
    assign device_reset_o = reset_pulse_reg;
    assign nmi_o = nmi_pulse_reg;
    assign wake_o = nmi_pulse_reg;
    assign irq_o = |(status_reg & mask_reg);

endmodule

`default_nettype wire

/* hdl/watchdog_timer_pkg.sv */
package watchdog_timer_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [31:0] WDOG_CTRL_ADDR = 32'hbf80_0000;
    localparam logic [31:0] WDOG_CTRL_CLR_ADDR = 32'hbf80_0004;
    localparam logic [31:0] WDOG_CTRL_SET_ADDR = 32'hbf80_0008;
    localparam logic [31:0] WDOG_CTRL_INV_ADDR = 32'hbf80_000c;
    localparam logic [31:0] EVT_STATUS_ADDR = 32'hbf80_0010;
    localparam logic [31:0] EVT_MASK_ADDR = 32'hbf80_0014;
    localparam logic [31:0] CAUSE_ADDR = 32'hbf80_f600;
    localparam logic [31:0] CAUSE_CLR_ADDR = 32'hbf80_f604;
    localparam logic [31:0] CAUSE_SET_ADDR = 32'hbf80_f608;
    localparam logic [31:0] CAUSE_INV_ADDR = 32'hbf80_f60c;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_ON_BIT = 15;
    localparam int CTRL_PS_LSB = 2;
    localparam int CTRL_PS_W = 5;
    localparam int CTRL_CLR_BIT = 0;
    localparam int CAUSE_TIMEOUT_BIT = 4;
    localparam int CAUSE_SLEEP_BIT = 3;
    localparam int CAUSE_IDLE_BIT = 2;
    localparam int EVT_TIMEOUT_BIT = 0;
    localparam int EVT_SERVICE_BIT = 1;
    localparam int EVT_W = 2;

    // ----------------------------------------
    // Reset values and sizes
    // ----------------------------------------
    localparam logic CTRL_ON_RST = 1'b0;
    localparam logic [2:0] CAUSE_RST = 3'h0;
    localparam logic [1:0] EVT_RST = 2'h0;
    localparam int CNT_W = 32;
    localparam logic [4:0] PS_MAX = 5'h1f;

    typedef enum logic [3:0] {
        WR_PLAIN = 4'b0001,
        WR_CLEAR = 4'b0010,
        WR_SET = 4'b0100,
        WR_INVERT = 4'b1000
    } write_kind_t;

endpackage

/* verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
    import watchdog_timer_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [31:0] addr_i = 32'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic cfg_enable_i = 1'b0;
    logic [4:0] cfg_postscale_i = 5'h1;
    logic sleep_i = 1'b0;
    logic idle_i = 1'b0;
    logic low_power_osc_clock_i = 1'b0;
    logic [31:0] rdata_o;
    logic device_reset_o, nmi_o, wake_o, irq_o;
    logic [31:0] d;
    int err_count = 0;
    int n_tests = 0;
    int rst_cnt = 0;
    int nmi_cnt = 0;
    int wake_cnt = 0;

    // ----------------------------------------
    // Harness
    // ----------------------------------------
    always #50 clk_i = ~clk_i;

    // Pulses last one cycle, so count them rather than poll
    always @(posedge clk_i)
    begin
        if (device_reset_o === 1'b1) rst_cnt <= rst_cnt + 1;
        if (nmi_o === 1'b1) nmi_cnt <= nmi_cnt + 1;
        if (wake_o === 1'b1) wake_cnt <= wake_cnt + 1;
    end

    watchdog_timer u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .cfg_enable_i(cfg_enable_i), .cfg_postscale_i(cfg_postscale_i),
        .sleep_i(sleep_i), .idle_i(idle_i), .low_power_osc_clock_i(low_power_osc_clock_i),
        .device_reset_o(device_reset_o), .nmi_o(nmi_o), .wake_o(wake_o), .irq_o(irq_o));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        chk(d, exp);
    endtask

    // Oscillator high and low three clocks each, well under clk/2
    task automatic tick();
        @(posedge clk_i);
        low_power_osc_clock_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        low_power_osc_clock_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rc(WDOG_CTRL_ADDR, 32'h4);
        rc(CAUSE_ADDR, 32'h0);
        rc(WDOG_CTRL_SET_ADDR, 32'h0);
        rc(32'hbf80_0020, 32'h0);
        $display("t_reset done");
    endtask

    task automatic t_awake();
        wr(EVT_MASK_ADDR, 32'h1);
        wr(WDOG_CTRL_SET_ADDR, 32'h8000);
        rc(WDOG_CTRL_ADDR, 32'h8004);
        // A counter clocked by the system clock would have timed out long before this
        repeat (20) @(posedge clk_i);
        #1 chk(rst_cnt, 0);
        tick();
        chk(rst_cnt, 0);
        tick();
        chk(rst_cnt, 1);
        chk(nmi_cnt, 0);
        chk(wake_cnt, 0);
        rc(WDOG_CTRL_ADDR, 32'h4);
        rc(CAUSE_ADDR, 32'h10);
        chk(irq_o, 1);
        rc(EVT_STATUS_ADDR, 32'h1);
        chk(irq_o, 0);
        $display("t_awake done");
    endtask

    task automatic t_service();
        wr(WDOG_CTRL_INV_ADDR, 32'h8001);
        rc(WDOG_CTRL_ADDR, 32'h8004);
        rc(EVT_STATUS_ADDR, 32'h2);
        tick();
        wr(WDOG_CTRL_ADDR, 32'h8001);
        tick();
        chk(rst_cnt, 1);
        tick();
        chk(rst_cnt, 2);
        wr(WDOG_CTRL_SET_ADDR, 32'h8000);
        wr(WDOG_CTRL_CLR_ADDR, 32'h8000);
        tick();
        tick();
        chk(rst_cnt, 2);
        $display("t_service done");
    endtask

    task automatic t_sleep();
        wr(CAUSE_CLR_ADDR, 32'h1c);
        @(posedge clk_i);
        cfg_postscale_i <= 5'h0;
        cfg_enable_i <= 1'b1;
        sleep_i <= 1'b1;
        tick();
        chk(nmi_cnt, 1);
        chk(wake_cnt, 1);
        chk(rst_cnt, 2);
        rc(CAUSE_ADDR, 32'h18);
        @(posedge clk_i);
        sleep_i <= 1'b0;
        idle_i <= 1'b1;
        wr(CAUSE_CLR_ADDR, 32'h1c);
        rc(CAUSE_ADDR, 32'h0);
        wr(WDOG_CTRL_CLR_ADDR, 32'h8000);
        tick();
        chk(nmi_cnt, 2);
        chk(wake_cnt, 2);
        rc(CAUSE_ADDR, 32'h14);
        wr(CAUSE_INV_ADDR, 32'h1c);
        rc(CAUSE_ADDR, 32'h8);
        wr(CAUSE_SET_ADDR, 32'h10);
        rc(CAUSE_ADDR, 32'h18);
        rc(WDOG_CTRL_ADDR, 32'h8000);
        $display("t_sleep done");
    endtask

    initial
    begin
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_awake();
        t_service();
        t_sleep();
        finish_test();
    end

    // The scenarios need about 150 cycles
    initial
    begin
        repeat (3000) @(posedge clk_i);
        err_count++;
        finish_test();
    end
endmodule

bind watchdog_timer watchdog_timer_props u_props (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cfg_enable_i(cfg_enable_i),
    .cfg_postscale_i(cfg_postscale_i), .sleep_i(sleep_i), .idle_i(idle_i),
    .low_power_osc_clock_i(low_power_osc_clock_i), .device_reset_o(device_reset_o), .nmi_o(nmi_o),
    .wake_o(wake_o), .irq_o(irq_o));

`default_nettype wire

/* verification/watchdog_timer_props.sv */
`timescale 1ns/10ps
`default_nettype none

module watchdog_timer_props
    import watchdog_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // Configuration, mode and oscillator
    input wire logic cfg_enable_i,
    input wire logic [4:0] cfg_postscale_i,
    input wire logic sleep_i,
    input wire logic idle_i,
    input wire logic low_power_osc_clock_i,
    // Device effects
    input wire logic device_reset_o,
    input wire logic nmi_o,
    input wire logic wake_o,
    input wire logic irq_o
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_ctrl_rd;
        rd_i && addr_i == WDOG_CTRL_ADDR;
    endsequence
    sequence s_alias_rd;
        rd_i && addr_i[31:4] == 28'hbf80000 && addr_i[3:0] != 4'h0;
    endsequence

    a_ctrl_ps_mirror: assert property (s_ctrl_rd |=> rdata_o[6:2] == $past(cfg_postscale_i))
        else $error("postscale field wrong");
    a_clr_reads_zero: assert property (s_ctrl_rd |=> !rdata_o[0])
        else $error("clear bit reads one");
    a_cfg_on_reads: assert property (s_ctrl_rd ##0 cfg_enable_i |=> rdata_o[15])
        else $error("enable bit not reported");
    a_alias_rd_zero: assert property (s_alias_rd |=> rdata_o == 32'h0)
        else $error("alias read not zero");
    a_reset_pulse: assert property (device_reset_o |=> !device_reset_o)
        else $error("device reset longer than one cycle");
    a_reset_awake: assert property (device_reset_o |-> !$past(sleep_i) && !$past(idle_i) && !nmi_o)
        else $error("device reset while asleep");
    a_nmi_mode: assert property (nmi_o |-> $past(sleep_i || idle_i) && wake_o)
        else $error("interrupt without sleep or idle");
    a_nmi_pulse: assert property (nmi_o |=> !nmi_o)
        else $error("interrupt longer than one cycle");
    a_tick_cause: assert property (device_reset_o || nmi_o |-> $past(low_power_osc_clock_i, 2))
        else $error("timeout without oscillator tick");
endmodule

`default_nettype wire
